// [core/dual_timer_pkg.sv]
package dual_timer_pkg;

  // ---------------------------------------------------------------------------
  // Mode field encodings
  // ---------------------------------------------------------------------------
  localparam logic [2:0] MODE_TIMER8 = 3'h0;   // 8-bit timer / event counter
  localparam logic [2:0] MODE_DIVOUT = 3'h1;   // Divider output
  localparam logic [2:0] MODE_PWM8 = 3'h2;     // 8-bit PWM (not built here)
  localparam logic [2:0] MODE_RSVD = 3'h3;     // Reserved, also low stage of cascade
  localparam logic [2:0] MODE_TIMER16 = 3'h4;  // 16-bit timer / event counter
  localparam logic [2:0] MODE_WARMUP = 3'h5;   // Warm-up counter (not built here)
  localparam logic [2:0] MODE_PWM16 = 3'h6;    // 16-bit PWM (not built here)
  localparam logic [2:0] MODE_PPG16 = 3'h7;    // 16-bit pulse generation (not built here)

  // ---------------------------------------------------------------------------
  // Clock select field encodings
  // ---------------------------------------------------------------------------
  localparam logic [2:0] CK_TAP_LOW = 3'h0;    // Lowest tap, depends on tap select
  localparam logic [2:0] CK_FC_DIV7 = 3'h1;    // High-freq / 2^7
  localparam logic [2:0] CK_FC_DIV5 = 3'h2;    // High-freq / 2^5
  localparam logic [2:0] CK_FC_DIV3 = 3'h3;    // High-freq / 2^3
  localparam logic [2:0] CK_FS = 3'h4;         // Raw low-freq clock
  localparam logic [2:0] CK_FC_DIV1 = 3'h5;    // High-freq / 2
  localparam logic [2:0] CK_FC = 3'h6;         // Raw high-freq clock
  localparam logic [2:0] CK_PIN = 3'h7;        // External event pin

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] COUNT_RST = 8'h00;    // Counter after reset or stop
  localparam logic TFF_RST = 1'b0;             // Timer flip-flop after reset

  // ---------------------------------------------------------------------------
  // Control carrier
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic flipflop_init_bit;       // Initial value for the timer flip-flop
    logic [2:0] clock_select_field;
    logic [2:0] mode_select_field;
    logic run_control_bit;         // 1 runs, 0 stops and clears
  } timer_control_reg_t;

  // Tick taps presented by the prescaler, one pulse per source edge
  typedef struct packed {
    logic fc;
    logic fc_div1;
    logic fc_div3;
    logic fc_div5;
    logic fc_div7;
    logic fc_div11;
    logic fs;
    logic fs_div3;
  } clock_taps_t;

endpackage

// [core/event_edge_detect.sv]
`timescale 1ns/1ps
// Two-flop synchroniser plus falling edge detector for the event pin
module event_edge_detect
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Pin and result
  input wire logic i_pin,
  output logic o_fall
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic meta;   // First stage, read only by the second stage
    logic sync;   // Second stage
    logic prev;   // Previous synchronised level
    logic fall;   // Registered falling edge pulse
  } edge_state_t;

  edge_state_t state_q;
  edge_state_t state_d;

  // Next state: shift the pin through and compare settled stages only
  always_comb
  begin
    state_d = state_q;
    state_d.meta = i_pin;
    state_d.sync = state_q.meta;
    state_d.prev = state_q.sync;
    state_d.fall = state_q.prev & ~state_q.sync;
  end

  // Stages idle high and the pulse idle low, so reset itself gives no false edge
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      state_q <= 4'hE;
    else
      state_q <= state_d;
  end

  assign o_fall = state_q.fall;

  // One falling edge gives exactly one pulse
  fall_single_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_fall |=> !o_fall) else $error("edge pulse longer than one cycle");

endmodule

// [core/timer_stage.sv]
`timescale 1ns/1ps
// One 8-bit up-counter with compare and match pulse
module timer_stage
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Control
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic i_cmp_en,
  input wire logic [WIDTH-1:0] i_cmp,
  // Results
  output logic [WIDTH-1:0] o_count,
  output logic o_match,
  output logic o_wrap
);

  // Elaboration check: a counter needs at least one bit
  if (WIDTH < 1)
  begin : g_width_check
    $error("timer_stage width must be positive");
  end

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic hit;

  // Compare reads the live compare value, no shadow copy
  assign hit = i_cmp_en && (count_q + 1'b1 == i_cmp);

  always_comb
  begin
    count_d = count_q;
    if (!i_run)
      count_d = '0;
    else if (i_tick && hit)
      count_d = '0;
    else if (i_tick)
      count_d = count_q + 1'b1;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      count_q <= '0;
    else
      count_q <= count_d;
  end

  assign o_count = count_q;
  assign o_match = i_run && i_tick && hit;
  assign o_wrap = i_run && i_tick && (&count_q);

endmodule

// [core/dual_timer.sv]
`timescale 1ns/1ps
// Contract
// - timer mode counts, matches, clears, continues
// - event mode counts falling pin edges
// - compare value takes effect immediately
// - divider mode toggles flip-flop on match
// - divider pin is inverse of flip-flop
// - flip-flop loadable, reset clears it
// - divider output is square wave
// - stopped divider holds output level
// - stages chain into 16-bit counter
// - low-speed modes offer limited clocks
// - clock select picks taps or pin
// - mode field encodes operating modes
module dual_timer
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Control words for the low and high stage
  input wire dual_timer_pkg::timer_control_reg_t i_ctrl_lo,
  input wire dual_timer_pkg::timer_control_reg_t i_ctrl_hi,
  input wire logic i_tff_wr_lo,
  input wire logic i_tff_wr_hi,
  // Compare values
  input wire logic [7:0] i_compare_value_reg_lo,
  input wire logic [7:0] i_compare_value_reg_hi,
  // Clocking context
  input wire dual_timer_pkg::clock_taps_t i_taps,
  input wire logic i_prescaler_tap_select,
  input wire logic i_low_speed_power_mode,
  // Event pins
  input wire logic i_event_in_pin_lo,
  input wire logic i_event_in_pin_hi,
  // Outputs
  output logic o_divider_out_pin_lo,
  output logic o_divider_out_pin_hi,
  output logic o_match_irq_lo,
  output logic o_match_irq_hi,
  output logic [15:0] o_count
);

  // ---------------------------------------------------------------------------
  // Event pin edges
  // ---------------------------------------------------------------------------
  logic fall_lo;
  logic fall_hi;

  event_edge_detect u_edge_lo
  (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_pin(i_event_in_pin_lo),
    .o_fall(fall_lo)
  );

  event_edge_detect u_edge_hi
  (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_pin(i_event_in_pin_hi),
    .o_fall(fall_hi)
  );

  // ---------------------------------------------------------------------------
  // Source tick selection
  // ---------------------------------------------------------------------------
  // Pick one tick per stage; in low-speed modes only permitted taps pass
  function automatic logic pick_tick(input logic [2:0] sel, input logic [2:0] mode,
                                     input dual_timer_pkg::clock_taps_t t,
                                     input logic tap_sel, input logic slow,
                                     input logic pin_fall);
    logic r;
    r = 1'b0;
    if (sel == dual_timer_pkg::CK_TAP_LOW)
      r = (tap_sel || slow) ? t.fs_div3 : t.fc_div11;
    else if (sel == dual_timer_pkg::CK_PIN)
      r = pin_fall;
    else if (slow)
      // Only the raw low clock survives, and only for 8-bit PWM
      r = (sel == dual_timer_pkg::CK_FS) && (mode == dual_timer_pkg::MODE_PWM8)
          && t.fs;
    else if (sel == dual_timer_pkg::CK_FC_DIV7)
      r = t.fc_div7;
    else if (sel == dual_timer_pkg::CK_FC_DIV5)
      r = t.fc_div5;
    else if (sel == dual_timer_pkg::CK_FC_DIV3)
      r = t.fc_div3;
    else if (sel == dual_timer_pkg::CK_FS)
      r = t.fs;
    else if (sel == dual_timer_pkg::CK_FC_DIV1)
      r = t.fc_div1;
    else
      r = t.fc;
    return r;
  endfunction

  logic cascade;
  logic tick_lo;
  logic tick_hi;
  logic run;
  logic run_hi;

  // Upper stage in 16-bit timer mode forms the cascade
  assign cascade = (i_ctrl_hi.mode_select_field == dual_timer_pkg::MODE_TIMER16);
  // Cascade runs from the upper stage's run bit and lower stage clock
  assign run = cascade ? i_ctrl_hi.run_control_bit : i_ctrl_lo.run_control_bit;
  assign run_hi = i_ctrl_hi.run_control_bit;
  assign tick_lo = pick_tick(i_ctrl_lo.clock_select_field, i_ctrl_lo.mode_select_field,
                             i_taps, i_prescaler_tap_select, i_low_speed_power_mode,
                             fall_lo);

  // ---------------------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------------------
  logic [7:0] cnt_lo;
  logic [7:0] cnt_hi;
  logic match_lo;
  logic match_hi;
  logic wrap_lo;
  logic hit16;
  logic [15:0] cmp16;
  logic [15:0] cnt16;

  assign cmp16 = {i_compare_value_reg_hi, i_compare_value_reg_lo};
  assign cnt16 = {cnt_hi, cnt_lo};
  // Full 16-bit compare against the next count value
  assign hit16 = cascade && run && tick_lo && (cnt16 + 16'h0001 == cmp16);

  // Lower stage: standalone compare, or free carry in cascade
  timer_stage #(.WIDTH(8)) u_stage_lo
  (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_run(run && !hit16),
    .i_tick(tick_lo),
    .i_cmp_en(!cascade),
    .i_cmp(i_compare_value_reg_lo),
    .o_count(cnt_lo),
    .o_match(match_lo),
    .o_wrap(wrap_lo)
  );

  // Upper stage ticks on lower overflow when chained
  assign tick_hi = cascade ? wrap_lo
                   : pick_tick(i_ctrl_hi.clock_select_field, i_ctrl_hi.mode_select_field,
                               i_taps, i_prescaler_tap_select, i_low_speed_power_mode,
                               fall_hi);

  timer_stage #(.WIDTH(8)) u_stage_hi
  (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_run(run_hi && !hit16),
    .i_tick(tick_hi),
    .i_cmp_en(!cascade),
    .i_cmp(i_compare_value_reg_hi),
    .o_count(cnt_hi),
    .o_match(match_hi),
    .o_wrap()
  );

  // ---------------------------------------------------------------------------
  // Output state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic tff_lo;
    logic tff_hi;
    logic pin_lo;
    logic pin_hi;
    logic irq_lo;
    logic irq_hi;
    logic [15:0] count;
  } out_state_t;

  out_state_t st_q;
  out_state_t st_d;
  logic div_lo;
  logic div_hi;

  assign div_lo = (i_ctrl_lo.mode_select_field == dual_timer_pkg::MODE_DIVOUT);
  assign div_hi = (i_ctrl_hi.mode_select_field == dual_timer_pkg::MODE_DIVOUT);

  // Flip-flops, pins and match pulses
  always_comb
  begin
    st_d = st_q;
    // Load written only while stopped, so a stop holds the level
    if (i_tff_wr_lo && !i_ctrl_lo.run_control_bit)
      st_d.tff_lo = i_ctrl_lo.flipflop_init_bit;
    else if (div_lo && match_lo)
      st_d.tff_lo = ~st_q.tff_lo;
    if (i_tff_wr_hi && !i_ctrl_hi.run_control_bit)
      st_d.tff_hi = i_ctrl_hi.flipflop_init_bit;
    else if (div_hi && match_hi && !cascade)
      st_d.tff_hi = ~st_q.tff_hi;
    st_d.pin_lo = ~st_d.tff_lo;
    st_d.pin_hi = ~st_d.tff_hi;
    // One-cycle pulse with the clear
    st_d.irq_lo = match_lo && !cascade;
    st_d.irq_hi = cascade ? hit16 : match_hi;
    st_d.count = cnt16;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_q <= '0;
      st_q.tff_lo <= dual_timer_pkg::TFF_RST;
      st_q.tff_hi <= dual_timer_pkg::TFF_RST;
      st_q.pin_lo <= ~dual_timer_pkg::TFF_RST;
      st_q.pin_hi <= ~dual_timer_pkg::TFF_RST;
    end
    else
      st_q <= st_d;
  end

  assign o_divider_out_pin_lo = st_q.pin_lo;
  assign o_divider_out_pin_hi = st_q.pin_hi;
  assign o_match_irq_lo = st_q.irq_lo;
  assign o_match_irq_hi = st_q.irq_hi;
  assign o_count = st_q.count;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  pin_inverse_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_divider_out_pin_lo == ~st_q.tff_lo) else $error("pin not inverse");
  irq_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_match_irq_lo |=> !o_match_irq_lo) else $error("irq too long");
  clear_match_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    match_lo && !cascade |=> cnt_lo == dual_timer_pkg::COUNT_RST && o_match_irq_lo)
    else $error("no clear on match");
  stop_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !run && !cascade |=> cnt_lo == dual_timer_pkg::COUNT_RST)
    else $error("stop did not clear");
  div_toggle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    div_lo && match_lo && !i_tff_wr_lo |=> st_q.tff_lo != $past(st_q.tff_lo))
    else $error("no toggle on match");
  stop_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !i_ctrl_lo.run_control_bit && !i_tff_wr_lo |=> $stable(st_q.tff_lo))
    else $error("level moved while stopped");
  tff_load_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_tff_wr_lo && !i_ctrl_lo.run_control_bit
    |=> st_q.tff_lo == $past(i_ctrl_lo.flipflop_init_bit))
    else $error("flip-flop load lost");
  cascade_carry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    cascade && wrap_lo && run_hi && !hit16 |=> cnt_hi == $past(cnt_hi) + 8'h01)
    else $error("no carry into upper stage");
  event_count_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    run && !cascade && i_ctrl_lo.clock_select_field == dual_timer_pkg::CK_PIN
    && !fall_lo |=> cnt_lo == $past(cnt_lo) || cnt_lo == 8'h00)
    else $error("count without edge");

  match_c: cover property (@(posedge i_mclk) o_match_irq_lo);
  div_c: cover property (@(posedge i_mclk) div_lo && match_lo);
  casc_c: cover property (@(posedge i_mclk) o_match_irq_hi && cascade);
  event_c: cover property (@(posedge i_mclk) fall_lo && run);

endmodule

// [testbench/event_pin_model.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Event pulse source and divider pin load
// ---------------------------------------------------------------------------
module event_pin_model
(
  // Clock
  input wire logic i_mclk,
  // Divider pin as seen by the load
  input wire logic i_divider_out_pin,
  // Event pin and loaded pad
  output logic o_event_pin,
  output logic o_pad
);
  // Port latch set high before the divider pin is used
  logic port_latch;
  initial port_latch = 1'b1;
  initial o_event_pin = 1'b1;
  // Pad follows the pin only through a latch held at one
  assign o_pad = port_latch & i_divider_out_pin;
  // Falling pulses; short widths are stretched so the sampler never misses one
  task automatic pulses(input int n, input int w);
    int hw;
    hw = (w < 2) ? 2 : w;
    for (int i = 0; i < n; i++)
    begin
      @(negedge i_mclk);
      o_event_pin = 1'b0;
      repeat (hw) @(negedge i_mclk);
      o_event_pin = 1'b1;
      repeat (hw - 1) @(negedge i_mclk);
    end
  endtask
endmodule

// [testbench/dual_8bit_timer_divider_tb_top.sv]
`timescale 1ns/1ps
module dual_8bit_timer_divider_tb_top;
  // ---------------------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------------------
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  dual_timer_pkg::timer_control_reg_t ctrl_lo = '0;
  dual_timer_pkg::timer_control_reg_t ctrl_hi = '0;
  logic tff_wr_lo = 1'b0;
  logic tff_wr_hi = 1'b0;
  logic [7:0] cmp_lo = 8'h00;
  logic [7:0] cmp_hi = 8'h00;
  logic [7:0] div = 8'h00; // Free tap divider
  dual_timer_pkg::clock_taps_t taps;
  logic tap_sel = 1'b0;
  logic slow = 1'b0;
  logic ev_lo;
  logic pin_lo, pin_hi, irq_lo, irq_hi, pad;
  logic [15:0] count;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_irq_lo = 0;
  int cyc = 0;
  int exp_p[7] = '{512, 256, 64, 16, 8, 4, 2}; // Period per clock code at compare 2
  // Ticks: fc each cycle, other taps at coarse fixed rates
  assign taps = {1'b1, div[0], &div[2:0], &div[4:0], &div[6:0], &div, &div[1:0], &div[3:0]};
  always #5 i_mclk = ~i_mclk;
  always @(negedge i_mclk) div <= div + 8'h01;
  // ---------------------------------------------------------------------------
  // Design and partner
  // ---------------------------------------------------------------------------
  dual_timer dual_timer_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ctrl_lo(ctrl_lo),
    .i_ctrl_hi(ctrl_hi), .i_tff_wr_lo(tff_wr_lo), .i_tff_wr_hi(tff_wr_hi),
    .i_compare_value_reg_lo(cmp_lo), .i_compare_value_reg_hi(cmp_hi), .i_taps(taps),
    .i_prescaler_tap_select(tap_sel), .i_low_speed_power_mode(slow),
    .i_event_in_pin_lo(ev_lo), .i_event_in_pin_hi(1'b1), .o_divider_out_pin_lo(pin_lo),
    .o_divider_out_pin_hi(pin_hi), .o_match_irq_lo(irq_lo), .o_match_irq_hi(irq_hi),
    .o_count(count));
  event_pin_model event_pin_model_i (.i_mclk(i_mclk), .i_divider_out_pin(pin_lo),
    .o_event_pin(ev_lo), .o_pad(pad));
  // Low stage match counter and hang guard
  always @(posedge i_mclk)
  begin
    if (irq_lo === 1'b1) n_irq_lo <= n_irq_lo + 1;
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  // ---------------------------------------------------------------------------
  // Compare, drive and measure tasks
  // ---------------------------------------------------------------------------
  // Four-state arguments so an unknown result cannot slip through as zero
  task automatic cmp_int(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic cmp_bit(input string nm, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
      n_mismatch++;
    end
  endtask
  // Stop with old settings, then program and start in one write
  task automatic start(input int s, input logic [2:0] ck, input logic [2:0] md,
                       input logic [15:0] cv);
    @(negedge i_mclk);
    if (s == 0) ctrl_lo.run_control_bit = 1'b0;
    else ctrl_hi.run_control_bit = 1'b0;
    @(negedge i_mclk);
    if (s == 0) cmp_lo = cv[7:0];
    else {cmp_hi, cmp_lo} = cv;
    if (s == 0) ctrl_lo = {1'b0, ck, md, 1'b1};
    else ctrl_hi = {1'b0, ck, md, 1'b1};
    n_irq_lo = 0;
  endtask
  // Cycles between two match pulses, and the pulse width
  task automatic meas(input int s, input string nm, input int exp);
    int n;
    n = 0;
    while (((s == 0) ? irq_lo : irq_hi) !== 1'b1 && n < 900)
    begin
      @(negedge i_mclk);
      n++;
    end
    @(negedge i_mclk);
    cmp_bit("irq width", 1'b0, (s == 0) ? irq_lo : irq_hi);
    n = 1;
    while (((s == 0) ? irq_lo : irq_hi) !== 1'b1 && n < 900)
    begin
      @(negedge i_mclk);
      n++;
    end
    cmp_int(nm, exp, n);
  endtask
  // Cycles between two edges of the low divider pin
  task automatic pin_width(input int exp);
    logic p;
    int n;
    p = pin_lo;
    n = 0;
    while (pin_lo === p && n < 900)
    begin
      @(negedge i_mclk);
      n++;
    end
    p = pin_lo;
    n = 0;
    while (pin_lo === p && n < 900)
    begin
      @(negedge i_mclk);
      n++;
    end
    cmp_int("divider width", exp, n);
  endtask
  // Flip-flop load through the write strobe while stopped
  task automatic load_ff(input logic v);
    @(negedge i_mclk);
    ctrl_lo.flipflop_init_bit = v;
    tff_wr_lo = 1'b1;
    @(negedge i_mclk);
    tff_wr_lo = 1'b0;
    repeat (2) @(negedge i_mclk);
    cmp_bit("pin after load", ~v, pin_lo);
  endtask
  // ---------------------------------------------------------------------------
  // Closing report
  // ---------------------------------------------------------------------------
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (2) @(negedge i_mclk);
    cmp_bit("reset pin", 1'b1, pin_lo);
    cmp_bit("reset irq", 1'b0, irq_lo);
    cmp_int("reset count", 0, count);
    i_rst_b = 1'b1;
    // Timer mode over every internal clock code
    for (int k = 0; k < 7; k++)
    begin
      start(0, 3'(k), dual_timer_pkg::MODE_TIMER8, 16'h0002);
      meas(0, "timer period", exp_p[k]);
    end
    cmp_bit("timer pin", 1'b1, pin_lo);
    // Compare value used live
    start(0, dual_timer_pkg::CK_FC, dual_timer_pkg::MODE_TIMER8, 16'h0064);
    repeat (3) @(negedge i_mclk);
    cmp_lo = 8'h06;
    repeat (8) @(negedge i_mclk);
    cmp_int("live compare", 1, n_irq_lo);
    // Low speed clock limits
    slow = 1'b1;
    tap_sel = 1'b1;
    start(0, dual_timer_pkg::CK_TAP_LOW, dual_timer_pkg::MODE_TIMER8, 16'h0002);
    meas(0, "slow tap period", 32);
    start(0, dual_timer_pkg::CK_FC_DIV3, dual_timer_pkg::MODE_TIMER8, 16'h0002);
    repeat (100) @(negedge i_mclk);
    cmp_int("slow refused", 0, n_irq_lo);
    slow = 1'b0;
    tap_sel = 1'b0;
    // Event counting on pin falls
    start(0, dual_timer_pkg::CK_PIN, dual_timer_pkg::MODE_TIMER8, 16'h0003);
    event_pin_model_i.pulses(2, 3);
    repeat (6) @(negedge i_mclk);
    cmp_int("event count", 2, count[7:0]);
    event_pin_model_i.pulses(1, 2);
    repeat (6) @(negedge i_mclk);
    cmp_int("event match", 1, n_irq_lo);
    cmp_int("event cleared", 0, count[7:0]);
    // Divider output square wave, stop hold, flip-flop loads
    start(0, dual_timer_pkg::CK_FC, dual_timer_pkg::MODE_DIVOUT, 16'h0002);
    pin_width(2);
    pin_width(2);
    cmp_bit("pad", pin_lo, pad);
    @(negedge i_mclk);
    ctrl_lo.run_control_bit = 1'b0;
    @(negedge i_mclk);
    begin
      logic held;
      held = pin_lo;
      repeat (10) @(negedge i_mclk);
      cmp_bit("held pin", held, pin_lo);
    end
    cmp_int("stopped count", 0, count[7:0]);
    load_ff(1'b1);
    load_ff(1'b0);
    // Cascade: lower clock select, upper control, full 16-bit compare
    ctrl_lo = {1'b0, dual_timer_pkg::CK_FC, dual_timer_pkg::MODE_RSVD, 1'b0};
    start(1, dual_timer_pkg::CK_PIN, dual_timer_pkg::MODE_TIMER16, 16'h0102);
    meas(1, "cascade period", 258);
    cmp_int("cascade low irq", 0, n_irq_lo);
    final_report();
  end
endmodule
